// File: uart_data_buffer_control_test.sv
// self-checking bench for the buffer control block
`timescale 1ns/100ps
`default_nettype none
module uart_data_buffer_control_test;
    localparam int D = 4;
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we_i = 1'b0, take = 1'b0, rxv = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dato, rd, seed = 32'h0001_7802;
    logic ack, irq, txv, txr, rxr, ov = 1'b0, en = 1'b0;
    logic [15:0] txw, rxw = 16'h0, m;
    logic [2:0] rxs = 3'h0;
    logic [3:0] wlen;
    logic [1:0] pr;
    logic [15:0] txq[$], rxq[$];
    int miscompares = 0, num_checks = 0, wl = 0;
    int fb[4] = '{7, 15, 16, 17};
    udb_buffer_ctrl #(.DEPTH(D)) dut (.REF_CLK(clk), .SRST(srst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we_i), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(dato), .WB_ACK_O(ack), .IRQ(irq), .TX_WORD(txw), .TX_WORD_VALID(txv),
        .TX_WORD_TAKE(take), .RX_WORD(rxw), .RX_FRAME_STATUS(rxs), .RX_WORD_VALID(rxv),
        .TX_PATH_RESET(txr), .RX_PATH_RESET(rxr), .WORD_LENGTH_SEL(wlen));
    always #4 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] sts();
        return {22'h0, txq.size() == D, txq.size() == 0, 4'h0, ov, 1'b0,
            rxq.size() == D, rxq.size() == 0};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we_i <= we;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dato;
        pr = {txr, rxr};
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic push(input logic [15:0] d, input logic [2:0] s);
        rxw <= d;
        rxs <= s;
        rxv <= 1'b1;
        @(posedge clk);
        rxv <= 1'b0;
        @(posedge clk);
        m = (wl == 0) ? 16'hffff : 16'((32'h1 << wl) - 1);
        m = d & m;
        if (rxq.size() < D)
            rxq.push_back({s, m[12:0]});
        else
            ov = 1'b1;
    endtask
    task automatic irqchk();
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, ov & en}, {31'h0, irq});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdchk("control", 8'h38, 32'h0);
        rdchk("status", 8'h3c, sts());
        rdchk("mask", 8'h40, 32'h8);
        rdchk("length", 8'h2c, 32'h0);
        rdchk("rx empty read", 8'h34, 32'h0);
        rdchk("unmapped", 8'h50, 32'h0);
        // one word past full must be dropped
        for (int i = 0; i <= D; i++) begin
            seed = lfsr(seed);
            wb(1'b1, 8'h30, seed);
            if (txq.size() < D)
                txq.push_back(seed[15:0]);
        end
        rdchk("tx full status", 8'h3c, sts());
        while (txq.size() > 0) begin
            chk("tx head", {15'h0, 1'b1, txq.pop_front()}, {15'h0, txv, txw});
            take <= 1'b1;
            @(posedge clk);
            take <= 1'b0;
            @(posedge clk);
        end
        rdchk("tx empty status", 8'h3c, sts());
        wb(1'b1, 8'h2c, 32'h0000_0800);
        wl = 8;
        chk("length sel", 32'h8, {28'h0, wlen});
        for (int i = 0; i <= D; i++) begin
            seed = lfsr(seed);
            push(seed[15:0], seed[18:16]);
        end
        rdchk("rx overrun status", 8'h3c, sts());
        irqchk();
        wb(1'b1, 8'h38, 32'h0000_4000);
        en = 1'b1;
        irqchk();
        wb(1'b1, 8'h38, 32'h0);
        en = 1'b0;
        irqchk();
        wb(1'b1, 8'h38, 32'h0000_4000);
        en = 1'b1;
        while (rxq.size() > 0)
            rdchk("rx word", 8'h34, {16'h0, rxq.pop_front()});
        wb(1'b1, 8'h3c, 32'h8);
        ov = 1'b0;
        irqchk();
        for (int k = 0; k < 4; k++) begin
            // receiver idle: no word is in flight when a path reset is asked for
            push(16'h0a5c, 3'h5);
            push(16'h1234, 3'h2);
            wb(1'b1, 8'h30, 32'h0000_00c3);
            txq.push_back(16'h00c3);
            wb(1'b1, 8'h38, 32'h0000_4000 | (32'h1 << fb[k]));
            if (fb[k] == 7 || fb[k] == 16)
                txq.delete();
            else
                rxq.delete();
            chk("reset pulse", {30'h0, fb[k] == 16, fb[k] == 17}, {30'h0, pr});
            rdchk("control self clear", 8'h38, 32'h0000_4000);
            chk("pulse cleared", 32'h0, {30'h0, txr, rxr});
            rdchk("flush status", 8'h3c, sts());
            chk("tx valid", {31'h0, txq.size() != 0}, {31'h0, txv});
            m = (rxq.size() > 0) ? rxq.pop_front() : 16'h0;
            rdchk("rx after flush", 8'h34, {16'h0, m});
            wb(1'b1, 8'h38, 32'h0003_4000);
            chk("both path resets", 32'h3, {30'h0, pr});
            txq.delete();
            rxq.delete();
        end
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire

// File: udb_buffer_ctrl.sv
// transmit and receive word buffers with wishbone register access
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module udb_buffer_ctrl #(
    parameter int DEPTH = udb_pkg::BUF_DEPTH
) (
    input wire logic REF_CLK,            // block clock, 125 MHz
    input wire logic SRST,               // synchronous reset, high
    input wire logic WB_CYC_I,           // wishbone cycle
    input wire logic WB_STB_I,           // wishbone strobe
    input wire logic WB_WE_I,            // wishbone write enable
    input wire logic [7:0] WB_ADR_I,     // wishbone byte address
    input wire logic [3:0] WB_SEL_I,     // wishbone byte enables
    input wire logic [31:0] WB_DAT_I,    // wishbone write data
    output logic [31:0] WB_DAT_O,        // wishbone read data
    output logic WB_ACK_O,               // wishbone acknowledge
    output logic IRQ,                    // level interrupt, high active
    output logic [15:0] TX_WORD,         // transmit buffer head word
    output logic TX_WORD_VALID,          // transmit buffer holds a word
    input wire logic TX_WORD_TAKE,       // shift engine takes head word
    input wire logic [15:0] RX_WORD,     // received data word
    input wire logic [2:0] RX_FRAME_STATUS, // break, framing, parity
    input wire logic RX_WORD_VALID,      // received word strobe
    output logic TX_PATH_RESET,          // transmit engine reset pulse
    output logic RX_PATH_RESET,          // receive engine reset pulse
    output logic [3:0] WORD_LENGTH_SEL   // word length to the engines
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    function automatic logic [15:0] word_mask(input logic [3:0] sel);
        word_mask = (sel == 4'h0) ? 16'hffff : 16'((17'h1 << sel) - 17'h1);
    endfunction

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : AW'(p + AW'(1));
    endfunction

    logic [AW-1:0] tx_wptr, tx_rptr, rx_wptr, rx_rptr;
    logic [AW-1:0] next_tx_wptr, next_tx_rptr, next_rx_wptr, next_rx_rptr;
    logic [CW-1:0] tx_count, rx_count, next_tx_count, next_rx_count;
    logic rx_path_reset, tx_path_reset, rx_buffer_flush, tx_buffer_flush;
    logic next_rx_path_reset, next_tx_path_reset;
    logic next_rx_buffer_flush, next_tx_buffer_flush;
    logic rx_overrun_irq_enable, next_rx_overrun_irq_enable;
    logic rx_overrun_flag, next_rx_overrun_flag;
    logic [3:0] irq_mask, next_irq_mask;
    logic [3:0] word_length_sel, next_word_length_sel;
    logic [31:0] next_dat_o;
    logic next_ack, next_irq, next_tx_valid;
    logic req, wr, rd, tx_push, tx_pop, rx_push, rx_pop, overrun;
    logic [15:0] tx_wdata, rx_wdata, rx_head;
    logic [31:0] status_word, control_word;

    assign WORD_LENGTH_SEL = word_length_sel;

    udb_word_mem #(.WIDTH(udb_pkg::WORD_W), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
        .clk(REF_CLK),
        .srst(SRST),
        .we(tx_push),
        .waddr(tx_wptr),
        .wdata(tx_wdata),
        .raddr(next_tx_rptr),
        .rdata(TX_WORD)
    );

    udb_word_mem #(.WIDTH(udb_pkg::WORD_W), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
        .clk(REF_CLK),
        .srst(SRST),
        .we(rx_push),
        .waddr(rx_wptr),
        .wdata(rx_wdata),
        .raddr(next_rx_rptr),
        .rdata(rx_head)
    );

    always_comb begin
        // the ack term keeps a held strobe from taking a second access in its acknowledge cycle
        req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        wr = req && WB_WE_I;
        rd = req && !WB_WE_I;
        next_ack = req;
    end

    // transmit side; a write into a full buffer is dropped
    always_comb begin
        tx_wdata = WB_DAT_I[udb_pkg::WORD_LSB +: udb_pkg::WORD_W]
                   & word_mask(word_length_sel);
        tx_push = wr && (WB_ADR_I == udb_pkg::OFS_TRANSMIT_WORD)
                  && (WB_SEL_I[0] || WB_SEL_I[1]) && (tx_count != FULL_COUNT)
                  && !tx_buffer_flush && !tx_path_reset;
        tx_pop = TX_WORD_TAKE && (tx_count != '0);
        next_tx_wptr = tx_push ? ptr_inc(tx_wptr) : tx_wptr;
        next_tx_rptr = tx_pop ? ptr_inc(tx_rptr) : tx_rptr;
        next_tx_count = CW'(tx_count + CW'(tx_push) - CW'(tx_pop));
        if (tx_path_reset) begin
            next_tx_wptr = '0;
            next_tx_rptr = '0;
            next_tx_count = '0;
        end else if (tx_buffer_flush) begin
            next_tx_rptr = tx_wptr;
            next_tx_count = '0;
        end
        // valid follows the next count, in step with the registered head word
        next_tx_valid = (next_tx_count != '0);
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            tx_wptr <= '0;
            tx_rptr <= '0;
            tx_count <= '0;
            TX_WORD_VALID <= 1'b0;
        end else begin
            tx_wptr <= next_tx_wptr;
            tx_rptr <= next_tx_rptr;
            tx_count <= next_tx_count;
            TX_WORD_VALID <= next_tx_valid;
        end
    end

    // receive side; status rides in the top bits of each word
    // words arriving during a flush or path reset are lost, with no overrun
    always_comb begin
        rx_wdata = RX_WORD & word_mask(word_length_sel);
        rx_wdata[udb_pkg::RX_FRAME_STATUS_LSB +: udb_pkg::RX_FRAME_STATUS_W] =
            RX_FRAME_STATUS;
        overrun = RX_WORD_VALID && (rx_count == FULL_COUNT)
                  && !rx_path_reset && !rx_buffer_flush;
        rx_push = RX_WORD_VALID && (rx_count != FULL_COUNT)
                  && !rx_path_reset && !rx_buffer_flush;
        rx_pop = rd && (WB_ADR_I == udb_pkg::OFS_RECEIVED_WORD) && (rx_count != '0);
        next_rx_wptr = rx_push ? ptr_inc(rx_wptr) : rx_wptr;
        next_rx_rptr = rx_pop ? ptr_inc(rx_rptr) : rx_rptr;
        next_rx_count = CW'(rx_count + CW'(rx_push) - CW'(rx_pop));
        if (rx_path_reset) begin
            next_rx_wptr = '0;
            next_rx_rptr = '0;
            next_rx_count = '0;
        end else if (rx_buffer_flush) begin
            next_rx_rptr = rx_wptr;
            next_rx_count = '0;
        end
    end

    // stored words need no reset; the count keeps stale ones unread
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rx_wptr <= '0;
            rx_rptr <= '0;
            rx_count <= '0;
        end else begin
            rx_wptr <= next_rx_wptr;
            rx_rptr <= next_rx_rptr;
            rx_count <= next_rx_count;
        end
    end

    // control pulses last only the cycle after the write
    // a second write cannot land in the pulse cycle: the ack term spaces accesses
    always_comb begin
        next_rx_path_reset = 1'b0;
        next_tx_path_reset = 1'b0;
        next_rx_buffer_flush = 1'b0;
        next_tx_buffer_flush = 1'b0;
        next_rx_overrun_irq_enable = rx_overrun_irq_enable;
        next_irq_mask = irq_mask;
        next_word_length_sel = word_length_sel;
        if (wr && (WB_ADR_I == udb_pkg::OFS_BUFFER_CONTROL)) begin
            if (WB_SEL_I[2]) begin
                next_rx_path_reset = WB_DAT_I[udb_pkg::CTL_RX_PATH_RESET];
                next_tx_path_reset = WB_DAT_I[udb_pkg::CTL_TX_PATH_RESET];
            end
            if (WB_SEL_I[1]) begin
                next_rx_buffer_flush = WB_DAT_I[udb_pkg::CTL_RX_BUFFER_FLUSH];
                next_rx_overrun_irq_enable =
                    WB_DAT_I[udb_pkg::CTL_RX_OVERRUN_IRQ_ENABLE];
            end
            if (WB_SEL_I[0]) begin
                next_tx_buffer_flush = WB_DAT_I[udb_pkg::CTL_TX_BUFFER_FLUSH];
            end
        end
        if (wr && (WB_ADR_I == udb_pkg::OFS_WORD_LENGTH) && WB_SEL_I[1]) begin
            next_word_length_sel = WB_DAT_I[udb_pkg::WLEN_LSB +: udb_pkg::WLEN_W];
        end
        if (wr && (WB_ADR_I == udb_pkg::OFS_IRQ_MASK) && WB_SEL_I[0]) begin
            next_irq_mask = WB_DAT_I[3:0];
        end
    end

    // engine pulses come straight from flops so they cannot glitch
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rx_path_reset <= 1'b0;
            tx_path_reset <= 1'b0;
            rx_buffer_flush <= 1'b0;
            tx_buffer_flush <= 1'b0;
            rx_overrun_irq_enable <= 1'b0;
            irq_mask <= udb_pkg::RST_IRQ_MASK;
            word_length_sel <= udb_pkg::RST_WORD_LENGTH_SEL;
            TX_PATH_RESET <= 1'b0;
            RX_PATH_RESET <= 1'b0;
        end else begin
            rx_path_reset <= next_rx_path_reset;
            tx_path_reset <= next_tx_path_reset;
            rx_buffer_flush <= next_rx_buffer_flush;
            tx_buffer_flush <= next_tx_buffer_flush;
            rx_overrun_irq_enable <= next_rx_overrun_irq_enable;
            irq_mask <= next_irq_mask;
            word_length_sel <= next_word_length_sel;
            TX_PATH_RESET <= next_tx_path_reset;
            RX_PATH_RESET <= next_rx_path_reset;
        end
    end

    // a new overrun beats a clear in the same cycle
    always_comb begin
        next_rx_overrun_flag = rx_overrun_flag;
        if (wr && (WB_ADR_I == udb_pkg::OFS_BUFFER_STATUS) && WB_SEL_I[0]
            && WB_DAT_I[udb_pkg::STS_RX_OVERRUN]) begin
            next_rx_overrun_flag = 1'b0;
        end
        if (overrun) begin
            next_rx_overrun_flag = 1'b1;
        end
        next_irq = next_rx_overrun_flag && next_rx_overrun_irq_enable
                   && next_irq_mask[udb_pkg::STS_RX_OVERRUN];
    end

    // next values feed the irq so it rises with the flag, not a cycle late
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rx_overrun_flag <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            rx_overrun_flag <= next_rx_overrun_flag;
            IRQ <= next_irq;
        end
    end

    // read data
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[udb_pkg::STS_TX_BUFFER_FULL] = (tx_count == FULL_COUNT);
        status_word[udb_pkg::STS_TX_BUFFER_EMPTY] = (tx_count == '0);
        status_word[udb_pkg::STS_RX_OVERRUN] = rx_overrun_flag;
        status_word[udb_pkg::STS_RX_BUFFER_FULL] = (rx_count == FULL_COUNT);
        status_word[udb_pkg::STS_RX_BUFFER_EMPTY] = (rx_count == '0);
        control_word = 32'h0000_0000;
        control_word[udb_pkg::CTL_RX_PATH_RESET] = rx_path_reset;
        control_word[udb_pkg::CTL_TX_PATH_RESET] = tx_path_reset;
        control_word[udb_pkg::CTL_RX_BUFFER_FLUSH] = rx_buffer_flush;
        control_word[udb_pkg::CTL_RX_OVERRUN_IRQ_ENABLE] = rx_overrun_irq_enable;
        control_word[udb_pkg::CTL_TX_BUFFER_FLUSH] = tx_buffer_flush;
        next_dat_o = 32'h0000_0000;
        if (rd) begin
            unique case (WB_ADR_I)
                udb_pkg::OFS_RECEIVED_WORD: begin
                    // empty buffer reads as zero rather than a stale word
                    if (rx_count != '0) begin
                        next_dat_o = {16'h0000, rx_head};
                    end
                end
                udb_pkg::OFS_BUFFER_CONTROL: next_dat_o = control_word;
                udb_pkg::OFS_BUFFER_STATUS: next_dat_o = status_word;
                udb_pkg::OFS_WORD_LENGTH: begin
                    next_dat_o[udb_pkg::WLEN_LSB +: udb_pkg::WLEN_W] = word_length_sel;
                end
                udb_pkg::OFS_IRQ_MASK: next_dat_o = {28'h0000000, irq_mask};
                default: next_dat_o = 32'h0000_0000;
            endcase
        end
    end

    // ack comes from a flop, so every access answers in exactly one cycle
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            WB_DAT_O <= 32'h0000_0000;
            WB_ACK_O <= 1'b0;
        end else begin
            WB_DAT_O <= next_dat_o;
            WB_ACK_O <= next_ack;
        end
    end
endmodule
`default_nettype wire

// File: udb_buffer_ctrl_properties.sv
// port-level assertions for the buffer control block
`timescale 1ns/100ps
`default_nettype none
module udb_buffer_ctrl_props (
    input wire logic REF_CLK, // clock
    input wire logic SRST, // reset
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [7:0] WB_ADR_I, // address
    input wire logic [3:0] WB_SEL_I, // byte enables
    input wire logic [31:0] WB_DAT_I, // write data
    input wire logic [31:0] WB_DAT_O, // read data
    input wire logic WB_ACK_O, // acknowledge
    input wire logic IRQ, // interrupt
    input wire logic [15:0] TX_WORD, // transmit head
    input wire logic TX_WORD_VALID, // transmit head valid
    input wire logic TX_WORD_TAKE, // transmit pop
    input wire logic TX_PATH_RESET, // transmit reset pulse
    input wire logic RX_PATH_RESET // receive reset pulse
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic req, wr, wctl;
    logic [15:0] wlo;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = req && WB_WE_I;
    assign wctl = wr && WB_ADR_I == udb_pkg::OFS_BUFFER_CONTROL;
    assign wlo = WB_DAT_I[15:0];
    sequence one_pulse(s);
        s ##1 !s;
    endsequence
    ack_latency_a: assert property (req |=> WB_ACK_O)
        else $error("no acknowledge one cycle after request");
    rd_data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside acknowledge");
    rx_reset_pulse_a: assert property (wctl && WB_SEL_I[2] && WB_DAT_I[17]
        |=> one_pulse(RX_PATH_RESET)) else $error("receive reset pulse wrong");
    tx_reset_pulse_a: assert property (wctl && WB_SEL_I[2] && WB_DAT_I[16]
        |=> one_pulse(TX_PATH_RESET)) else $error("transmit reset pulse wrong");
    rx_reset_quiet_a: assert property (wctl && !WB_DAT_I[17] |=> !RX_PATH_RESET)
        else $error("receive reset without a one written");
    tx_reset_quiet_a: assert property (wctl && !WB_DAT_I[16] |=> !TX_PATH_RESET)
        else $error("transmit reset without a one written");
    tx_flush_empty_a: assert property (wctl && WB_SEL_I[0] && WB_DAT_I[7]
        |-> ##[1:3] !TX_WORD_VALID) else $error("transmit flush left words");
    tx_reset_empty_a: assert property (TX_PATH_RESET |-> ##[0:2] !TX_WORD_VALID)
        else $error("transmit reset left words");
    tx_word_queued_a: assert property (wr && WB_ADR_I == udb_pkg::OFS_TRANSMIT_WORD
        && WB_SEL_I[0] && !TX_WORD_VALID && !TX_WORD_TAKE
        |=> TX_WORD_VALID && TX_WORD == $past(wlo)) else $error("transmit word not queued");
    irq_disable_a: assert property (wctl && WB_SEL_I[1] && !WB_DAT_I[14]
        |-> ##[1:3] !IRQ) else $error("interrupt stays with enable off");
endmodule
bind udb_buffer_ctrl udb_buffer_ctrl_props props_i (.REF_CLK, .SRST, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ, .TX_WORD,
    .TX_WORD_VALID, .TX_WORD_TAKE, .TX_PATH_RESET, .RX_PATH_RESET);
`default_nettype wire

// File: udb_pkg.sv
// shared constants for the serial data buffer control block
package udb_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_WORD_LENGTH = 8'h2c;
    localparam logic [7:0] OFS_TRANSMIT_WORD = 8'h30;
    localparam logic [7:0] OFS_RECEIVED_WORD = 8'h34;
    localparam logic [7:0] OFS_BUFFER_CONTROL = 8'h38;
    localparam logic [7:0] OFS_BUFFER_STATUS = 8'h3c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

    // reset values
    localparam logic [31:0] RST_BUFFER_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_BUFFER_STATUS = 32'h0000_0101;
    localparam logic [3:0] RST_WORD_LENGTH_SEL = 4'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h8;

    // data word fields
    localparam int WORD_W = 16;
    localparam int WORD_LSB = 0;
    localparam int RX_FRAME_STATUS_LSB = 13;
    localparam int RX_FRAME_STATUS_W = 3;

    // buffer control fields
    localparam int CTL_RX_PATH_RESET = 17;
    localparam int CTL_TX_PATH_RESET = 16;
    localparam int CTL_RX_BUFFER_FLUSH = 15;
    localparam int CTL_RX_OVERRUN_IRQ_ENABLE = 14;
    localparam int CTL_TX_BUFFER_FLUSH = 7;

    // buffer status fields; the mask register uses the same layout
    localparam int STS_TX_BUFFER_FULL = 9;
    localparam int STS_TX_BUFFER_EMPTY = 8;
    localparam int STS_RX_OVERRUN = 3;
    localparam int STS_RX_BUFFER_FULL = 1;
    localparam int STS_RX_BUFFER_EMPTY = 0;

    // word length select field
    localparam int WLEN_LSB = 8;
    localparam int WLEN_W = 4;

    // default buffer depth in words
    localparam int BUF_DEPTH = 4;
endpackage

// File: udb_word_mem.sv
// small word store with registered read data and write-to-read bypass
`timescale 1ns/100ps
`default_nettype none
module udb_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic clk,              // block clock
    input wire logic srst,             // synchronous reset, high
    input wire logic we,               // write strobe
    input wire logic [AW-1:0] waddr,   // write address
    input wire logic [WIDTH-1:0] wdata, // write data
    input wire logic [AW-1:0] raddr,   // read address
    output logic [WIDTH-1:0] rdata     // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    // bypass so a word written into an empty buffer shows at once
    always_comb begin
        next_rdata = mem[raddr];
        if (we && (waddr == raddr)) begin
            next_rdata = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire
